// ---- i2cw_top.sv ----
// Purpose: Master transmit sequencing of a two-wire serial controller
// Assumes: Control bits arrive as ports on clk; link_clk paces the bus
// Notes: SCL is divided from link_clk, four phases of four cycles a bit
// How it works
// - Frame: start, address with write 0, ack, data bytes with ack, stop.
// - Address width mode concerns only our own slave address, not remote.
// - Transmit irq enable bit gates the transmit interrupt.
// - Interrupt asserts while enabled and the data register is empty.
// - Start bit causes a start condition on the bus when enabled in master mode.
// - After start, the data register is moved into the shift register.
// - After the first address bit leaves, the interrupt asserts again.
// - Remaining address bits and write bit shift out regardless.
`include "i2cw_params.svh"
module i2cw_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic controller_enable_bit,
    input wire logic master_mode,
    input wire logic own_addr_10bit,
    input wire logic transmit_irq_enable,
    input wire logic data_wr,
    input wire logic [7:0] data_in,
    input wire logic start_set,
    input wire logic stop_set,
    input wire logic sda_in,
    input wire logic scl_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out,
    output logic scl_oe_n,
    output logic transmit_buffer_empty_flag,
    output logic irq,
    output logic start_pending,
    output logic busy,
    output logic nack_flag,
    output logic own_addr_width_10
);
    i2cw_xfer_if u_xfer ();

    // Register side, clk domain
    logic [7:0] data_ff;
    logic [7:0] nxt_data;
    logic [7:0] xdata_ff;
    logic [7:0] nxt_xdata;
    logic empty_ff;
    logic nxt_empty;
    logic start_ff;
    logic nxt_start;
    logic stop_ff;
    logic nxt_stop;
    logic req_ff;
    logic nxt_req;
    logic ack_seen_ff;
    logic nxt_ack_seen;
    logic own10_ff;
    logic nxt_own10;
    logic ack_s;
    logic busy_s;
    logic nack_s;
    logic ack_ev;
    logic offer_pend;
    logic offer_go;
    logic en;

    // Link side, link_clk domain
    logic link_rst;
    logic en_s;
    logic master_s;
    logic start_s;
    logic stop_s;
    logic sda_s;
    logic scl_s;
    logic pend;
    logic take;
    logic stall;
    logic step;
    logic last;
    i2cw_pkg::i2cw_byte_t byte_q;
    i2cw_pkg::i2cw_link_st_e st_ff;
    i2cw_pkg::i2cw_link_st_e nxt_st;
    logic [1:0] ph_ff;
    logic [1:0] nxt_ph;
    logic [1:0] tk_ff;
    logic [1:0] nxt_tk;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic [7:0] sh_ff;
    logic [7:0] nxt_sh;
    logic sda_low_ff;
    logic nxt_sda_low;
    logic scl_low_ff;
    logic nxt_scl_low;
    logic nack_ff;
    logic nxt_nack;
    logic busy_ff;
    logic nxt_busy;

    // SCL pull-down per state and phase
    function automatic logic scl_drv(i2cw_pkg::i2cw_link_st_e s,
                                     logic [1:0] p);
        case (s)
            i2cw_pkg::L_START: scl_drv = p == `I2CW_PH_LAST;
            i2cw_pkg::L_BIT,
            i2cw_pkg::L_ACK,
            i2cw_pkg::L_RSTART,
            i2cw_pkg::L_STOP: scl_drv = p < `I2CW_PH_TWO;
            i2cw_pkg::L_WAIT: scl_drv = 1'h1;
            default: scl_drv = 1'h0;
        endcase
    endfunction : scl_drv

    // SDA pull-down per state and phase
    function automatic logic sda_drv(i2cw_pkg::i2cw_link_st_e s,
                                     logic [1:0] p, logic b);
        case (s)
            i2cw_pkg::L_START: sda_drv = p != 2'h0;
            i2cw_pkg::L_BIT: sda_drv = ~b;
            i2cw_pkg::L_STOP: sda_drv = p != `I2CW_PH_LAST;
            default: sda_drv = 1'h0;
        endcase
    endfunction : sda_drv

    // ---------------- clk domain ----------------
    i2cw_sync #(.W(3)) u_back (
        .clk(clk),
        .rst(sys_rst),
        .d({u_xfer.ack_tgl, busy_ff, nack_ff}),
        .q({ack_s, busy_s, nack_s})
    );

    assign en = controller_enable_bit;
    assign ack_ev = ack_s != ack_seen_ff;
    assign offer_pend = req_ff != ack_seen_ff;
    // A write in the same cycle defers the offer so no byte is lost
    assign offer_go = !empty_ff && !offer_pend && !data_wr && en
                      && (start_ff || busy_s);

    always_comb begin
        nxt_data = data_ff;
        nxt_empty = empty_ff;
        nxt_xdata = xdata_ff;
        nxt_req = req_ff;
        nxt_ack_seen = ack_s;
        nxt_own10 = own_addr_10bit;
        nxt_start = start_ff;
        nxt_stop = stop_ff;
        if (data_wr) begin
            nxt_data = data_in;
            nxt_empty = 1'h0;
        end
        if (ack_ev) begin
            nxt_empty = 1'h1;
        end
        if (offer_go) begin
            nxt_req = ~req_ff;
            nxt_xdata = data_ff;
        end
        if (ack_ev || !en) begin
            nxt_start = 1'h0;
        end
        if (start_set && en && master_mode) begin
            nxt_start = 1'h1;
        end
        if (!en || (!busy_s && !start_ff)) begin
            nxt_stop = 1'h0;
        end
        if (stop_set && en) begin
            nxt_stop = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_ff <= `I2CW_DATA_RST;
            empty_ff <= `I2CW_EMPTY_RST;
            xdata_ff <= `I2CW_DATA_RST;
            req_ff <= 1'h0;
            ack_seen_ff <= 1'h0;
            own10_ff <= 1'h0;
            start_ff <= 1'h0;
            stop_ff <= 1'h0;
        end else begin
            data_ff <= nxt_data;
            empty_ff <= nxt_empty;
            xdata_ff <= nxt_xdata;
            req_ff <= nxt_req;
            ack_seen_ff <= nxt_ack_seen;
            own10_ff <= nxt_own10;
            start_ff <= nxt_start;
            stop_ff <= nxt_stop;
        end
    end

    assign u_xfer.req_tgl = req_ff;
    assign u_xfer.data = xdata_ff;
    assign irq = en && transmit_irq_enable && empty_ff;
    assign transmit_buffer_empty_flag = empty_ff;
    assign start_pending = start_ff;
    assign busy = busy_s;
    assign nack_flag = nack_s;
    assign own_addr_width_10 = own10_ff;

    a_wr_clears_empty: assert property (@(posedge clk) disable iff (sys_rst)
        data_wr && !ack_ev |=> !empty_ff)
        else $error("empty flag did not clear on data write");
    a_empty_set_cause: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(empty_ff) |-> $past(ack_ev))
        else $error("empty flag set without link taking a byte");
    a_irq_needs_enable: assert property (@(posedge clk) disable iff (sys_rst)
        !transmit_irq_enable |-> !irq)
        else $error("interrupt raised while transmit irq disabled");
    a_irq_when_empty: assert property (@(posedge clk) disable iff (sys_rst)
        en && transmit_irq_enable && empty_ff |-> irq)
        else $error("interrupt missing while data register empty");

    // ---------------- link_clk domain ----------------
    i2cw_sync #(.W(1)) u_rst (
        .clk(link_clk),
        .rst(1'h0),
        .d(sys_rst),
        .q(link_rst)
    );

    i2cw_sync #(.W(6)) u_in (
        .clk(link_clk),
        .rst(link_rst),
        .d({en, master_mode, start_ff, stop_ff, sda_in, scl_in}),
        .q({en_s, master_s, start_s, stop_s, sda_s, scl_s})
    );

    i2cw_hs_dst u_dst (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .xfer(u_xfer),
        .take(take),
        .pending(pend),
        .byte_q(byte_q)
    );

    // A slave holding SCL low stretches the high phase
    assign stall = !scl_low_ff && !scl_s
                   && (st_ff == i2cw_pkg::L_BIT || st_ff == i2cw_pkg::L_ACK);
    assign step = (tk_ff == `I2CW_QTR_LAST) && !stall;
    assign last = step && (ph_ff == `I2CW_PH_LAST);

    always_comb begin
        nxt_st = st_ff;
        nxt_tk = stall ? tk_ff : tk_ff + 2'h1;
        nxt_ph = step ? ph_ff + 2'h1 : ph_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_nack = nack_ff;
        take = 1'h0;
        case (st_ff)
            i2cw_pkg::L_IDLE: begin
                nxt_tk = 2'h0;
                nxt_ph = 2'h0;
                if (en_s && master_s && start_s && pend) begin
                    nxt_st = i2cw_pkg::L_START;
                    nxt_nack = 1'h0;
                end
            end
            i2cw_pkg::L_START: begin
                if (last) begin
                    nxt_sh = byte_q;
                    nxt_cnt = `I2CW_BIT_FIRST;
                    nxt_st = i2cw_pkg::L_BIT;
                end
            end
            i2cw_pkg::L_BIT: begin
                if (last) begin
                    take = cnt_ff == `I2CW_BIT_FIRST;
                    if (cnt_ff == `I2CW_BIT_LAST) begin
                        nxt_st = i2cw_pkg::L_ACK;
                    end else begin
                        nxt_sh = {sh_ff[6:0], 1'h0};
                        nxt_cnt = cnt_ff + 3'h1;
                    end
                end
            end
            i2cw_pkg::L_ACK: begin
                if (last) begin
                    nxt_nack = sda_s;
                    nxt_st = sda_s ? i2cw_pkg::L_STOP : i2cw_pkg::L_WAIT;
                end
            end
            i2cw_pkg::L_WAIT: begin
                // SCL is held low until the next byte or an ending arrives
                nxt_tk = 2'h0;
                nxt_ph = 2'h0;
                if (!en_s) begin
                    nxt_st = i2cw_pkg::L_STOP;
                end else if (start_s && pend) begin
                    nxt_st = i2cw_pkg::L_RSTART;
                end else if (pend) begin
                    nxt_sh = byte_q;
                    nxt_cnt = `I2CW_BIT_FIRST;
                    nxt_st = i2cw_pkg::L_BIT;
                end else if (stop_s) begin
                    nxt_st = i2cw_pkg::L_STOP;
                end
            end
            i2cw_pkg::L_RSTART: begin
                if (last) begin
                    nxt_st = i2cw_pkg::L_START;
                    nxt_ph = `I2CW_PH_ONE;
                end
            end
            i2cw_pkg::L_STOP: begin
                if (last) begin
                    nxt_st = i2cw_pkg::L_IDLE;
                end
            end
            default: begin
                nxt_st = i2cw_pkg::L_IDLE;
            end
        endcase
        nxt_scl_low = scl_drv(nxt_st, nxt_ph);
        // SDA lags SCL by one link cycle so no edge of the two coincides
        nxt_sda_low = sda_drv(st_ff, ph_ff, sh_ff[7]);
        nxt_busy = nxt_st != i2cw_pkg::L_IDLE;
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            st_ff <= i2cw_pkg::L_IDLE;
            ph_ff <= 2'h0;
            tk_ff <= 2'h0;
            cnt_ff <= 3'h0;
            sh_ff <= `I2CW_DATA_RST;
            sda_low_ff <= 1'h0;
            scl_low_ff <= 1'h0;
            nack_ff <= 1'h0;
            busy_ff <= 1'h0;
        end else begin
            st_ff <= nxt_st;
            ph_ff <= nxt_ph;
            tk_ff <= nxt_tk;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            sda_low_ff <= nxt_sda_low;
            scl_low_ff <= nxt_scl_low;
            nack_ff <= nxt_nack;
            busy_ff <= nxt_busy;
        end
    end

    // Open drain: only ever pull low
    assign sda_out = 1'h0;
    assign scl_out = 1'h0;
    assign sda_oe_n = ~sda_low_ff;
    assign scl_oe_n = ~scl_low_ff;

    a_start_cond: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(sda_low_ff) && st_ff == i2cw_pkg::L_START
        |-> !scl_low_ff [*4])
        else $error("SDA fell without SCL high for a start");
    a_load_shift: assert property (@(posedge link_clk) disable iff (link_rst)
        st_ff == i2cw_pkg::L_START && nxt_st == i2cw_pkg::L_BIT
        |=> sh_ff == $past(byte_q))
        else $error("shift register not loaded after start");
    a_bit_on_sda: assert property (@(posedge link_clk) disable iff (link_rst)
        st_ff == i2cw_pkg::L_BIT && $past(st_ff) == i2cw_pkg::L_BIT
        |-> sda_low_ff == !$past(sh_ff[7]))
        else $error("SDA does not carry the shifted bit");
    a_first_bit_take: assert property (@(posedge link_clk)
        disable iff (link_rst)
        $rose(st_ff == i2cw_pkg::L_BIT && cnt_ff == 3'h1) |-> !pend)
        else $error("byte not released after first bit");
    a_eight_then_ack: assert property (@(posedge link_clk)
        disable iff (link_rst)
        $rose(st_ff == i2cw_pkg::L_ACK) |-> $past(cnt_ff) == 3'h7)
        else $error("acknowledge slot not after eight bits");
endmodule : i2cw_top

// ---- i2cw_params.svh ----
// Purpose: Constants for the two-wire master write controller
// Assumes: Included by bare name from each design file that needs them
// Notes: Phase counts are in link clock cycles
`ifndef I2CW_PARAMS_SVH
`define I2CW_PARAMS_SVH
`define I2CW_EMPTY_RST 1'h1
`define I2CW_DATA_RST 8'h00
`define I2CW_QTR_LAST 2'h3
`define I2CW_PH_LAST 2'h3
`define I2CW_PH_ONE 2'h1
`define I2CW_PH_TWO 2'h2
`define I2CW_BIT_FIRST 3'h0
`define I2CW_BIT_LAST 3'h7
`endif

// ---- i2cw_pkg.sv ----
// Purpose: Types shared by the two-wire master write controller
// Assumes: Nothing
// Notes: Link states are walked once per bit phase group
package i2cw_pkg;
    typedef enum logic [2:0] {
        L_IDLE,
        L_START,
        L_BIT,
        L_ACK,
        L_WAIT,
        L_RSTART,
        L_STOP
    } i2cw_link_st_e;
    typedef logic [7:0] i2cw_byte_t;
endpackage : i2cw_pkg

// ---- i2cw_xfer_if.sv ----
// Purpose: Byte handover from the register side to the link side
// Assumes: data is held stable while req_tgl differs from ack_tgl
// Notes: Toggle handshake, each side synchronises the other's toggle
interface i2cw_xfer_if;
    logic req_tgl;
    logic ack_tgl;
    i2cw_pkg::i2cw_byte_t data;
    modport src (
        output req_tgl,
        output data,
        input ack_tgl
    );
    modport dst (
        input req_tgl,
        input data,
        output ack_tgl
    );
endinterface : i2cw_xfer_if

// ---- i2cw_sync.sv ----
// Purpose: Two flip-flop level synchroniser
// Assumes: Each bit is an independent level
// Notes: Only the second stage is visible outside
module i2cw_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule : i2cw_sync

// ---- i2cw_hs_dst.sv ----
// Purpose: Link-side end of the byte handover
// Assumes: take is a one-cycle pulse on link_clk
// Notes: Data is read without synchronising; the source holds it still
module i2cw_hs_dst (
    input wire logic link_clk,
    input wire logic link_rst,
    i2cw_xfer_if.dst xfer,
    input wire logic take,
    output logic pending,
    output i2cw_pkg::i2cw_byte_t byte_q
);
    logic req_s;
    logic ack_ff;
    logic nxt_ack;

    i2cw_sync #(.W(1)) u_req (
        .clk(link_clk),
        .rst(link_rst),
        .d(xfer.req_tgl),
        .q(req_s)
    );

    always_comb begin
        nxt_ack = take ? ~ack_ff : ack_ff;
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            ack_ff <= 1'h0;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

    assign xfer.ack_tgl = ack_ff;
    assign pending = req_s != ack_ff;
    assign byte_q = xfer.data;
endmodule : i2cw_hs_dst

// ---- i2cw_slave_model.sv ----
// Purpose: Remote slave on the two-wire bus for the write controller bench
// Assumes: Lines are wired-and with pull-ups in the bench
// Notes: Acks only its own address with write bit 0; may stretch SCL low
module i2cw_slave_model #(
    parameter logic [6:0] SLV_ADDR = 7'h2A
) (
    input wire logic sda,
    input wire logic scl,
    input wire logic stretch,
    output logic sda_low,
    output logic scl_low,
    output logic [7:0] rx_byte,
    output int rx_cnt,
    output int start_cnt,
    output int stop_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh = 8'h00;
    logic first = 1'b0;
    int bit_n = -2;
    initial begin
        sda_low = 1'b0;
        scl_low = 1'b0;
        rx_byte = 8'h00;
        rx_cnt = 0;
        start_cnt = 0;
        stop_cnt = 0;
    end
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            start_cnt++;
            bit_n = -1;
            first = 1'b1;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            stop_cnt++;
            bit_n = -2;
        end
    end
    always @(posedge scl) begin
        if (bit_n >= 0 && bit_n < 8) begin
            sh = {sh[6:0], sda};
        end
    end
    always @(negedge scl) begin
        if (bit_n == 7) begin
            rx_byte = sh;
            rx_cnt++;
            // A wrong address or a read bit gets no acknowledge
            sda_low = !first || sh == {SLV_ADDR, 1'b0};
            first = 1'b0;
            bit_n = 8;
        end else if (bit_n == 8) begin
            sda_low = 1'b0;
            bit_n = 0;
            if (stretch) begin
                // Holding SCL low blocks this process, no edge can come
                scl_low = 1'b1;
                #2000;
                scl_low = 1'b0;
            end
        end else if (bit_n >= -1) begin
            bit_n++;
        end
    end
endmodule : i2cw_slave_model

// ---- i2cw_top_bench.sv ----
// Purpose: Self-checking bench for the two-wire master write controller
// Assumes: Slave model on wired-and lines with pull-ups
// Notes: Reset is held longer so the link side sees enough edges
module i2cw_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] SLV = 7'h2A;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst, en, mm, own10, txie, data_wr, start_set, stop_set;
    logic stretch, sda_w, scl_w, sda_out, sda_oe_n, scl_out, scl_oe_n;
    logic empty, irq, start_pending, busy, nack_flag, own_w10;
    logic sda_low, scl_low;
    logic [7:0] data_in, rx_byte;
    int rx_cnt, start_cnt, stop_cnt, error_cnt, n_checks, cyc;
    logic [7:0] got_q[$];
    logic [7:0] exp_q[$];
    always #50 clk = ~clk;
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end
    assign sda_w = (sda_oe_n !== 1'b0) && !sda_low;
    assign scl_w = (scl_oe_n !== 1'b0) && !scl_low;
    i2cw_top i_i2cw_top (
        .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .controller_enable_bit(en), .master_mode(mm),
        .own_addr_10bit(own10), .transmit_irq_enable(txie),
        .data_wr(data_wr), .data_in(data_in), .start_set(start_set),
        .stop_set(stop_set), .sda_in(sda_w), .scl_in(scl_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .transmit_buffer_empty_flag(empty),
        .irq(irq), .start_pending(start_pending), .busy(busy),
        .nack_flag(nack_flag), .own_addr_width_10(own_w10)
    );
    i2cw_slave_model #(.SLV_ADDR(SLV)) i_i2cw_slave_model (
        .sda(sda_w), .scl(scl_w), .stretch(stretch), .sda_low(sda_low),
        .scl_low(scl_low), .rx_byte(rx_byte), .rx_cnt(rx_cnt),
        .start_cnt(start_cnt), .stop_cnt(stop_cnt)
    );
    always @(rx_cnt) begin
        if (rx_cnt > 0) begin
            got_q.push_back(rx_byte);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            $display("Error at %0t: run timed out", $time);
            finish_test();
        end
    end
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr_byte(input logic [7:0] b);
        @(posedge clk);
        data_wr <= 1'b1;
        data_in <= b;
        @(posedge clk);
        data_wr <= 1'b0;
    endtask : wr_byte
    task automatic ctl(input logic st, input logic sp);
        @(posedge clk);
        start_set <= st;
        stop_set <= sp;
        @(posedge clk);
        start_set <= 1'b0;
        stop_set <= 1'b0;
    endtask : ctl
    // Bounded wait on the empty flag (idx 0) or busy (idx 1)
    task automatic wait_for(input int idx, input logic v, input int lim);
        int n;
        n = 0;
        @(negedge clk);
        while ((idx == 1 ? busy : empty) !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(8'(n < lim), 8'h01, "wait ran out");
    endtask : wait_for
    task automatic run_frame(input logic [6:0] a, input int n);
        logic [7:0] b;
        logic bad;
        int s0, p0;
        bad = a != SLV;
        s0 = start_cnt;
        p0 = stop_cnt;
        got_q.delete();
        exp_q.delete();
        own10 <= 1'($urandom);
        wr_byte({a, 1'b0});
        exp_q.push_back({a, 1'b0});
        @(negedge clk);
        chk(8'(empty), 8'h00, "empty after write");
        chk(8'(irq), 8'h00, "irq while full");
        ctl(1'b1, 1'b0);
        @(negedge clk);
        chk(8'(start_pending), 8'h01, "start pending");
        wait_for(1, 1'b1, 300);
        chk(8'(own_w10), 8'(own10), "own width copy");
        for (int i = 0; i <= n; i++) begin
            wait_for(0, 1'b1, 600);
            chk(8'(irq), 8'(txie), "irq after first bit");
            chk(8'(got_q.size()), 8'(i), "byte done too early");
            chk(8'(start_pending), 8'h00, "start still pending");
            if (i < n) begin
                b = i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($urandom);
                wr_byte(b);
                exp_q.push_back(b);
            end
        end
        // A refused address ends the frame on its own
        if (!bad) begin
            ctl(1'b0, 1'b1);
        end
        wait_for(1, 1'b0, 600);
        chk(8'(nack_flag), 8'(bad), "nack flag");
        chk(8'(start_cnt - s0), 8'h01, "start count");
        chk(8'(stop_cnt - p0), 8'h01, "stop count");
        chk(8'(got_q.size()), 8'(exp_q.size()), "byte count");
        foreach (exp_q[k]) begin
            chk(got_q[k], exp_q[k], "byte on the wire");
        end
        $display("Test frame to %h with %0d data bytes done", a, n);
    endtask : run_frame
    initial begin
        sys_rst = 1'b1;
        en = 1'b0;
        mm = 1'b1;
        own10 = 1'b0;
        txie = 1'b0;
        data_wr = 1'b0;
        data_in = 8'h00;
        start_set = 1'b0;
        stop_set = 1'b0;
        stretch = 1'b0;
        void'($urandom(32'h38D7A2F1));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk(8'(empty), 8'h01, "empty at reset");
        chk(8'({busy, sda_oe_n, scl_oe_n, sda_out, scl_out}), 8'h0C,
            "idle lines");
        $display("Test reset values done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            en <= k[0];
            txie <= k[1];
            @(negedge clk);
            chk(8'(irq), 8'(k[0] & k[1]), "irq gating");
        end
        $display("Test irq gating done");
        for (int k = 0; k < 2; k++) begin
            en <= k[0];
            mm <= !k[0];
            ctl(1'b1, 1'b0);
            repeat (3) @(negedge clk);
            chk(8'({start_pending, busy}), 8'h00, "start refused");
        end
        $display("Test start refusal done");
        en <= 1'b1;
        mm <= 1'b1;
        txie <= 1'b1;
        run_frame(SLV, 3);
        stretch = 1'b1;
        txie <= 1'b0;
        run_frame(SLV, 2);
        stretch = 1'b0;
        txie <= 1'b1;
        run_frame(SLV ^ 7'h01, 0);
        run_frame(SLV, 0);
        for (int k = 0; k < 3; k++) begin
            run_frame(SLV, 1 + int'($urandom % 3));
        end
        finish_test();
    end
endmodule : i2cw_top_bench
